// ### hdl/sleep_clock_gating_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Avalon-MM word addressing in bytes, 20 MHz clock
// Notes: Included by the gating block and the test bench
`ifndef SLEEP_CLOCK_GATING_CONSTS_SVH
`define SLEEP_CLOCK_GATING_CONSTS_SVH
`define ADDR_W 4
`define OFS_SLEEP_CTRL 4'h0
`define OFS_GATE 4'h4
`define OFS_STATUS 4'h8
`define OFS_CONFIG 4'hc
`define GATE_RESET 8'h00
`define GATE_WMASK 8'hef
`define BIT_TWI 7
`define BIT_TIM2 6
`define BIT_TIM0 5
`define BIT_RSVD 4
`define BIT_TIM1 3
`define BIT_SPI 2
`define BIT_UART 1
`define BIT_CONV 0
`define SEL_IDLE 3'h0
`define SEL_NOISE 3'h1
`define SEL_PDOWN 3'h2
`define SEL_PSAVE 3'h3
`define SEL_STANDBY 3'h6
`define STANDBY_WAKE_CYC 6
`define IRQ_HOLD_CYC 4
`define WAIT_W 16
`endif

// ### hdl/sleep_clock_gating_pkg.sv
// Purpose: Types for the sleep and clock gating block
// Assumes: Constants header provides field widths
// Notes: Types only
package sleep_clock_gating_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_SLEEP = 3'h1,
        ST_STARTUP = 3'h2,
        ST_HOLD = 3'h3
    } phase_t;

    typedef struct packed {
        logic conv_done;
        logic ext_reset;
        logic wdt_event;
        logic brownout;
        logic twi_match;
        logic tim2_irq;
        logic tim2_ovf;
        logic tim2_cmp;
        logic store_ready;
        logic ext_zero_level;
        logic ext_one_level;
        logic pin_change;
    } wake_src_t;

    typedef struct packed {
        logic core_clk_en;
        logic nvm_clk_en;
        logic io_clk_en;
        logic conv_clk_en;
        logic async_clk_en;
        logic main_osc_en;
        logic timer_osc_en;
        logic tim2_sync_clk_en;
    } clk_en_t;

    typedef struct packed {
        logic [7:0] gate_en;
        logic conv_start;
        logic comp_mux_block;
    } periph_ctl_t;

    typedef struct packed {
        phase_t phase;
        logic [2:0] sleep_sel;
        logic sleep_permit;
        logic [7:0] gate;
        logic [15:0] wait_cnt;
        logic irq_wake;
        logic [2:0] mode;
        logic standby_ok;
        clk_en_t clk;
        periph_ctl_t per;
        logic waitreq;
        logic [31:0] rdata;
        logic core_halt;
        logic resume;
    } state_t;
endpackage

// ### hdl/sleep_clock_gating_ctrl.sv
// Purpose: Sleep state sequencing and per-peripheral clock gating
// Assumes: Inputs synchronous to i_clk; startup count given in cycles
// Notes: Clock enables are outputs; gating cells sit outside
//
// Function
// - Noise reduction stops core, memory and I/O clocks; converter and async run.
// - Entering noise reduction starts a conversion when the converter is enabled.
// - Noise reduction wakes on its listed sources only.
// - Power-down stops oscillator and all generated clocks.
// - Power-down wakes on resets, watchdog, address match, level lines, pin change.
// - Wake from power-down waits a start-up period chosen by clock source setting.
// - Power-save is power-down but timer two keeps running when enabled.
// - Power-save wakes on timer two events when masked in and globally enabled.
// - Power-save stops unused timer two clock sources; sync clock only feeds timer two.
// - Standby with crystal keeps oscillator running and wakes in six cycles.
// - External lines wake deep sleep only in level mode.
// - Idle and noise reduction keep timer oscillator only with async timer two.
// - A set gating bit stops the peripheral clock and blocks its register access.
// - Clearing a gating bit resumes the peripheral in its frozen state.
// - Gating bits: 7 two-wire, 6 timer two, 5 timer zero, 3 timer one, 2 SPI, 1 uart, 0 conv.
// - Gating bit 4 ignores writes and reads zero.
// - Timer two gating acts only in synchronous mode.
// - A gated converter blocks comparator use of its input multiplexer.
// - Gating acts in active and idle; deeper states stop clocks anyway.
// - An interrupt wake holds the core four extra cycles then resumes.
`include "sleep_clock_gating_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sleep_clock_gating_ctrl #(
    parameter int STARTUP_CYC = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [`ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_sleep_instr,
    input wire logic i_crystal_option,
    input wire logic [`WAIT_W-1:0] i_startup_cycles,
    input wire logic i_timer_two_async_select,
    input wire logic i_tim2_enabled,
    input wire logic i_conv_enabled,
    input wire logic i_global_irq_en,
    input wire logic [1:0] i_timer_two_irq_mask,
    input wire logic i_ext_zero_level_mode,
    input wire logic i_ext_one_level_mode,
    input wire sleep_clock_gating_pkg::wake_src_t i_wake,
    output sleep_clock_gating_pkg::clk_en_t o_clk,
    output sleep_clock_gating_pkg::periph_ctl_t o_per,
    output logic o_core_halt,
    output logic o_resume
);
    import sleep_clock_gating_pkg::*;

    state_t s_reg;
    state_t s_next;
    logic [2:0] eff_mode;
    logic wake_any;
    logic wake_irq;

    // Reserved selects and standby without crystal fall back to power-down
    always_comb begin
        eff_mode = `SEL_PDOWN;
        case (s_reg.sleep_sel)
            `SEL_IDLE: eff_mode = `SEL_IDLE;
            `SEL_NOISE: eff_mode = `SEL_NOISE;
            `SEL_PSAVE: eff_mode = `SEL_PSAVE;
            `SEL_STANDBY: eff_mode = i_crystal_option ? `SEL_STANDBY : `SEL_PDOWN;
            default: eff_mode = `SEL_PDOWN;
        endcase
    end

    always_comb begin
        logic ext_lvl;
        logic tim2_wake;
        ext_lvl = (i_wake.ext_zero_level & i_ext_zero_level_mode)
            | (i_wake.ext_one_level & i_ext_one_level_mode);
        tim2_wake = i_global_irq_en & ((i_wake.tim2_ovf & i_timer_two_irq_mask[0])
            | (i_wake.tim2_cmp & i_timer_two_irq_mask[1]));
        wake_irq = i_wake.wdt_event | i_wake.twi_match | ext_lvl | i_wake.pin_change;
        case (s_reg.mode)
            `SEL_IDLE: wake_irq = 1'b1 & (|i_wake);
            `SEL_NOISE: wake_irq = wake_irq | i_wake.conv_done | i_wake.tim2_irq
                | i_wake.store_ready;
            `SEL_PSAVE: wake_irq = wake_irq | tim2_wake;
            default: wake_irq = wake_irq;
        endcase
        wake_any = wake_irq | i_wake.ext_reset | i_wake.brownout;
    end

    always_comb begin
        logic wr;
        logic rd;
        logic tim2_sync;
        s_next = s_reg;
        wr = 1'b0;
        rd = 1'b0;
        tim2_sync = ~i_timer_two_async_select;
        s_next.per.conv_start = 1'b0;
        s_next.resume = 1'b0;
        // Every access answers one cycle after it is seen
        if ((i_read | i_write) & s_reg.waitreq) begin
            s_next.waitreq = 1'b0;
            wr = i_write;
            rd = i_read;
        end else begin
            s_next.waitreq = 1'b1;
        end
        if (wr) begin
            case (i_address)
                `OFS_SLEEP_CTRL: begin
                    s_next.sleep_permit = i_writedata[0];
                    s_next.sleep_sel = i_writedata[3:1];
                end
                `OFS_GATE: s_next.gate = i_writedata[7:0] & `GATE_WMASK;
                default: s_next.gate = s_reg.gate;
            endcase
        end
        s_next.rdata = 32'h0;
        if (rd) begin
            case (i_address)
                `OFS_SLEEP_CTRL: s_next.rdata = {28'h0, s_reg.sleep_sel, s_reg.sleep_permit};
                `OFS_GATE: s_next.rdata = {24'h0, s_reg.gate};
                `OFS_STATUS: s_next.rdata = {24'h0, 1'b0, s_reg.mode, 1'b0, s_reg.phase};
                default: s_next.rdata = 32'h0;
            endcase
        end
        case (s_reg.phase)
            ST_RUN: begin
                // Sleep without permit is ignored
                if (i_sleep_instr & s_reg.sleep_permit) begin
                    s_next.phase = ST_SLEEP;
                    s_next.mode = eff_mode;
                    s_next.per.conv_start = (eff_mode == `SEL_NOISE) & i_conv_enabled;
                end
            end
            ST_SLEEP: begin
                if (wake_any) begin
                    s_next.irq_wake = wake_irq;
                    s_next.phase = ST_STARTUP;
                    if (s_reg.mode == `SEL_STANDBY) begin
                        s_next.wait_cnt = 16'(`STANDBY_WAKE_CYC - 1);
                    end else if (s_reg.mode == `SEL_PDOWN || s_reg.mode == `SEL_PSAVE) begin
                        s_next.wait_cnt = (i_startup_cycles == 16'h0) ? 16'h0
                            : i_startup_cycles - 16'h1;
                    end else begin
                        s_next.wait_cnt = 16'h0;
                    end
                end
            end
            ST_STARTUP: begin
                if (s_reg.wait_cnt == 16'h0) begin
                    s_next.phase = s_reg.irq_wake ? ST_HOLD : ST_RUN;
                    s_next.wait_cnt = 16'(`IRQ_HOLD_CYC - 1);
                    s_next.resume = ~s_reg.irq_wake;
                end else begin
                    s_next.wait_cnt = s_reg.wait_cnt - 16'h1;
                end
            end
            ST_HOLD: begin
                if (s_reg.wait_cnt == 16'h0) begin
                    s_next.phase = ST_RUN;
                    s_next.resume = 1'b1;
                end else begin
                    s_next.wait_cnt = s_reg.wait_cnt - 16'h1;
                end
            end
            default: s_next.phase = ST_RUN;
        endcase
        // Domain enables follow the phase actually being entered
        s_next.clk.core_clk_en = (s_next.phase == ST_RUN);
        s_next.clk.nvm_clk_en = (s_next.phase == ST_RUN);
        s_next.clk.io_clk_en = 1'b1;
        s_next.clk.conv_clk_en = 1'b1;
        s_next.clk.async_clk_en = 1'b1;
        s_next.clk.main_osc_en = 1'b1;
        s_next.clk.timer_osc_en = i_timer_two_async_select;
        s_next.clk.tim2_sync_clk_en = tim2_sync;
        if (s_next.phase == ST_SLEEP) begin
            case (s_next.mode)
                `SEL_IDLE: s_next.clk.io_clk_en = 1'b1;
                `SEL_NOISE: s_next.clk.io_clk_en = 1'b0;
                `SEL_PSAVE: begin
                    s_next.clk.io_clk_en = 1'b0;
                    s_next.clk.conv_clk_en = 1'b0;
                    s_next.clk.async_clk_en = i_tim2_enabled & i_timer_two_async_select;
                    s_next.clk.timer_osc_en = i_tim2_enabled & i_timer_two_async_select;
                    s_next.clk.main_osc_en = i_tim2_enabled & tim2_sync;
                    s_next.clk.tim2_sync_clk_en = i_tim2_enabled & tim2_sync;
                end
                default: begin
                    s_next.clk.io_clk_en = 1'b0;
                    s_next.clk.conv_clk_en = 1'b0;
                    s_next.clk.async_clk_en = 1'b0;
                    s_next.clk.timer_osc_en = 1'b0;
                    s_next.clk.tim2_sync_clk_en = 1'b0;
                    s_next.clk.main_osc_en = (s_next.mode == `SEL_STANDBY);
                end
            endcase
        end
        // Gating only matters while the domain clocks run
        for (int b = 0; b < 8; b++) begin
            s_next.per.gate_en[b] = ~s_next.gate[b];
        end
        s_next.per.gate_en[`BIT_TIM2] = ~(s_next.gate[`BIT_TIM2] & tim2_sync);
        s_next.per.gate_en[`BIT_RSVD] = 1'b0;
        s_next.per.comp_mux_block = s_next.gate[`BIT_CONV];
        s_next.core_halt = (s_next.phase != ST_RUN);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_reg <= '0;
            s_reg.gate <= `GATE_RESET;
            s_reg.waitreq <= 1'b1;
            s_reg.mode <= `SEL_IDLE;
            s_reg.clk <= '1;
            s_reg.per.gate_en <= 8'hef;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end

    assign o_readdata = s_reg.rdata;
    assign o_waitrequest = s_reg.waitreq;
    assign o_clk = s_reg.clk;
    assign o_per = s_reg.per;
    assign o_core_halt = s_reg.core_halt;
    assign o_resume = s_reg.resume;

    noise_clocks_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_reg.phase == ST_SLEEP && s_reg.mode == `SEL_NOISE) |->
        (!o_clk.core_clk_en && !o_clk.io_clk_en && o_clk.conv_clk_en))
        else $error("noise reduction clocks wrong");
    pdown_clocks_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_reg.phase == ST_SLEEP && s_reg.mode == `SEL_PDOWN) |->
        (!o_clk.main_osc_en && !o_clk.async_clk_en && !o_clk.conv_clk_en))
        else $error("power-down clocks running");
    standby_osc_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_reg.phase == ST_SLEEP && s_reg.mode == `SEL_STANDBY) |->
        (o_clk.main_osc_en && !o_clk.io_clk_en))
        else $error("standby oscillator stopped");
    standby_wake_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce)
        (s_reg.phase == ST_SLEEP && s_reg.mode == `SEL_STANDBY && wake_any && !wake_irq)
        ##1 i_ce [*6] |=> o_resume)
        else $error("standby wake not six cycles");
    gate_rsvd_a: assert property (@(posedge i_clk) disable iff (i_rst)
        s_reg.gate[`BIT_RSVD] == 1'b0)
        else $error("reserved gate bit set");
    conv_mux_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_per.comp_mux_block == s_reg.gate[`BIT_CONV])
        else $error("comparator mux not blocked");
    tim2_async_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_reg.gate[`BIT_TIM2] && $past(i_timer_two_async_select) && $past(i_ce))
        |-> o_per.gate_en[`BIT_TIM2])
        else $error("async timer two gated");
    permit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_reg.phase == ST_RUN && i_ce && i_sleep_instr && !s_reg.sleep_permit)
        |=> s_reg.phase == ST_RUN)
        else $error("sleep entered without permit");
    conv_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(s_reg.phase == ST_SLEEP) && s_reg.mode == `SEL_NOISE && $past(i_conv_enabled)
        |-> o_per.conv_start)
        else $error("conversion not started");
    irq_hold_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce)
        (s_reg.phase == ST_STARTUP && s_reg.wait_cnt == 16'h0 && s_reg.irq_wake)
        |=> (o_core_halt && !o_resume) [*4] ##1 o_resume)
        else $error("interrupt hold not four cycles");
endmodule
`default_nettype wire

// ### bench/wake_source_model.sv
// Purpose: Core and peripheral side, raises wake request levels
// Assumes: The bench raises sources as one-cycle masks
// Notes: Levels are held, since a pulse could slip past a stopped clock
`timescale 1ns/1ps
`default_nettype none
module wake_source_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire sleep_clock_gating_pkg::wake_src_t i_raise,
    input wire logic i_drop,
    input wire logic i_resume,
    output sleep_clock_gating_pkg::wake_src_t o_wake
);
    import sleep_clock_gating_pkg::*;
    wake_src_t held_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst || i_drop || i_resume) begin
            held_reg <= '0;
        end else begin
            held_reg <= held_reg | i_raise;
        end
    end
    assign o_wake = held_reg;
endmodule
`default_nettype wire

// ### bench/sleep_clock_gating_ctrl_test.sv
// Purpose: Self-checking bench for sleep sequencing and clock gating
// Assumes: Wake latency is judged by differences, except the absolute standby reset wake count
// Notes: Startup input set small to keep the run short
`include "sleep_clock_gating_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sleep_clock_gating_ctrl_test;
    import sleep_clock_gating_pkg::*;
    logic i_clk, i_rst, i_ce, i_read, i_write, i_sleep_instr, i_crystal_option, drop, saw_start;
    logic [3:0] i_address;
    logic [31:0] i_writedata, o_readdata;
    logic [15:0] i_startup_cycles;
    logic [1:0] i_timer_two_irq_mask;
    logic i_timer_two_async_select, i_tim2_enabled, i_conv_enabled, i_global_irq_en;
    logic i_ext_zero_level_mode, i_ext_one_level_mode, o_waitrequest, o_core_halt, o_resume;
    wake_src_t raise, wake;
    clk_en_t o_clk;
    periph_ctl_t o_per;
    int n_mismatch = 0;
    int comparisons = 0;
    int base_cyc;
    localparam wake_src_t W_PIN = 12'h001;
    localparam wake_src_t W_EXT0 = 12'h004;
    localparam wake_src_t W_STORE = 12'h008;
    localparam wake_src_t W_OVF = 12'h020;
    localparam wake_src_t W_RST = 12'h400;
    localparam wake_src_t W_CONV = 12'h800;

    sleep_clock_gating_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_sleep_instr(i_sleep_instr),
        .i_crystal_option(i_crystal_option), .i_startup_cycles(i_startup_cycles),
        .i_timer_two_async_select(i_timer_two_async_select), .i_tim2_enabled(i_tim2_enabled),
        .i_conv_enabled(i_conv_enabled), .i_global_irq_en(i_global_irq_en),
        .i_timer_two_irq_mask(i_timer_two_irq_mask), .i_ext_zero_level_mode(i_ext_zero_level_mode),
        .i_ext_one_level_mode(i_ext_one_level_mode), .i_wake(wake), .o_clk(o_clk),
        .o_per(o_per), .o_core_halt(o_core_halt), .o_resume(o_resume));
    wake_source_model partner (.i_clk(i_clk), .i_rst(i_rst), .i_raise(raise), .i_drop(drop),
        .i_resume(o_resume), .o_wake(wake));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp, input string what);
        comparisons++;
        if (got != exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        i_address <= a;
        i_writedata <= wd;
        i_write <= wr;
        i_read <= !wr;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        chk_cnt(n, 2, "bus answer");
        i_read <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic enter(input logic [2:0] sel);
        logic [31:0] rd;
        bus(1'b1, `OFS_SLEEP_CTRL, {28'h0, sel, 1'b1}, rd);
        saw_start = 1'b0;
        i_sleep_instr <= 1'b1;
        @(posedge i_clk);
        i_sleep_instr <= 1'b0;
        repeat (3) begin
            @(posedge i_clk);
            if (o_per.conv_start === 1'b1) saw_start = 1'b1;
        end
        chk(o_core_halt, 1'b1, "halt in sleep");
    endtask

    task automatic wake_up(input wake_src_t src, input int limit, output int cyc);
        raise <= src;
        @(posedge i_clk);
        raise <= '0;
        cyc = 0;
        while (o_resume !== 1'b1 && cyc < limit) begin
            @(posedge i_clk);
            cyc++;
        end
        if (cyc >= limit) cyc = -1;
    endtask

    task automatic cancel();
        drop <= 1'b1;
        @(posedge i_clk);
        drop <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic test_regs();
        logic [31:0] rd;
        chk(o_waitrequest, 1'b1, "idle waitrequest");
        bus(1'b0, `OFS_GATE, 0, rd);
        chk(rd, {24'h0, `GATE_RESET}, "gate reset");
        i_conv_enabled <= 1'b0;
        for (int b = 0; b < 8; b++) begin
            bus(1'b1, `OFS_GATE, 32'h1 << b, rd);
            bus(1'b0, `OFS_GATE, 0, rd);
            chk(rd, (b == `BIT_RSVD) ? 32'h0 : 32'h1 << b, "gate read");
            chk(o_per.gate_en, 8'hef & ~(8'h1 << b), "gate enables");
        end
        bus(1'b1, `OFS_GATE, 32'hff, rd);
        bus(1'b0, `OFS_GATE, 0, rd);
        chk(rd, 32'hef, "gate all");
        chk(o_per.gate_en, 8'h00, "all gated");
        chk(o_per.comp_mux_block, 1'b1, "mux blocked");
        i_timer_two_async_select <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk(o_per.gate_en, 8'h40, "async timer runs");
        i_timer_two_async_select <= 1'b0;
        bus(1'b1, `OFS_GATE, 0, rd);
        chk(o_per.gate_en, 8'hef, "ungated");
        chk(o_per.comp_mux_block, 1'b0, "mux free");
        bus(1'b1, 4'h2, 32'hff, rd);
        bus(1'b0, 4'h2, 0, rd);
        chk(rd, 0, "unmapped read");
        bus(1'b0, `OFS_GATE, 0, rd);
        chk(rd, 0, "unmapped write");
        bus(1'b1, `OFS_SLEEP_CTRL, 32'h4, rd);
        i_sleep_instr <= 1'b1;
        @(posedge i_clk);
        i_sleep_instr <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(o_core_halt, 1'b0, "no permit");
        $display("test regs done");
    endtask

    task automatic test_noise();
        int c;
        i_conv_enabled <= 1'b1;
        enter(`SEL_NOISE);
        chk(saw_start, 1'b1, "conv start");
        chk({o_clk.core_clk_en, o_clk.nvm_clk_en, o_clk.io_clk_en, o_clk.conv_clk_en,
             o_clk.async_clk_en}, 5'b00011, "noise clocks");
        chk(o_clk.timer_osc_en, 1'b0, "timer osc");
        wake_up(W_STORE, 100, c);
        chk(c >= 0, 1'b1, "noise wake");
        i_conv_enabled <= 1'b0;
        $display("test noise done");
    endtask

    task automatic test_pdown();
        int c, c_rst;
        i_startup_cycles <= 16'h4;
        i_ext_zero_level_mode <= 1'b0;
        enter(`SEL_PDOWN);
        chk(o_clk, 8'h00, "pdown clocks");
        wake_up(W_CONV, 40, c);
        chk_cnt(c, -1, "conv no wake");
        cancel();
        wake_up(W_EXT0, 40, c);
        chk_cnt(c, -1, "edge mode no wake");
        cancel();
        i_ext_zero_level_mode <= 1'b1;
        wake_up(W_EXT0, 100, base_cyc);
        chk(base_cyc >= 0, 1'b1, "level wake");
        enter(`SEL_PDOWN);
        wake_up(W_RST, 100, c_rst);
        chk_cnt(base_cyc - c_rst, `IRQ_HOLD_CYC, "irq hold");
        i_startup_cycles <= 16'ha;
        enter(`SEL_PDOWN);
        wake_up(W_PIN, 100, c);
        chk_cnt(c - base_cyc, 6, "startup wait");
        i_startup_cycles <= 16'h4;
        $display("test pdown done");
    endtask

    task automatic test_standby();
        int c;
        logic [31:0] rd;
        logic [2:0] rs[4] = '{3'h6, 3'h4, 3'h5, 3'h7};
        i_crystal_option <= 1'b1;
        enter(`SEL_STANDBY);
        chk({o_clk.main_osc_en, o_clk.core_clk_en}, 2'b10, "standby osc");
        wake_up(W_PIN, 100, c);
        chk_cnt(c - base_cyc, `STANDBY_WAKE_CYC - 4, "standby wake");
        enter(`SEL_STANDBY);
        wake_up(W_RST, 100, c);
        chk_cnt(c, `STANDBY_WAKE_CYC + 2, "standby reset wake");
        i_crystal_option <= 1'b0;
        foreach (rs[i]) begin
            enter(rs[i]);
            bus(1'b0, `OFS_STATUS, 0, rd);
            chk(rd[6:4], `SEL_PDOWN, "fallback mode");
            chk(o_clk.main_osc_en, 1'b0, "fallback osc");
            wake_up(W_PIN, 100, c);
            chk_cnt(c, base_cyc, "fallback wake");
        end
        $display("test standby done");
    endtask

    task automatic test_psave();
        int c;
        i_timer_two_async_select <= 1'b1;
        i_tim2_enabled <= 1'b1;
        i_timer_two_irq_mask <= 2'b01;
        i_global_irq_en <= 1'b0;
        enter(`SEL_PSAVE);
        chk({o_clk.core_clk_en, o_clk.main_osc_en, o_clk.timer_osc_en, o_clk.tim2_sync_clk_en},
            4'b0010, "psave clocks");
        wake_up(W_OVF, 40, c);
        chk_cnt(c, -1, "masked ovf");
        cancel();
        i_global_irq_en <= 1'b1;
        // A held enable low must keep the sleeping state from advancing
        i_ce <= 1'b0;
        wake_up(W_OVF, 40, c);
        chk_cnt(c, -1, "frozen by enable");
        cancel();
        i_ce <= 1'b1;
        wake_up(W_OVF, 100, c);
        chk_cnt(c, base_cyc, "ovf wake");
        i_timer_two_async_select <= 1'b0;
        i_global_irq_en <= 1'b0;
        $display("test psave done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        n_mismatch++;
        stop_test();
    end

    initial begin
        {i_rst, i_ce, i_read, i_write, i_sleep_instr, i_crystal_option, drop} = 7'b1100000;
        {i_address, i_writedata, i_startup_cycles, i_timer_two_irq_mask} = '0;
        {i_timer_two_async_select, i_tim2_enabled, i_conv_enabled, i_global_irq_en} = '0;
        {i_ext_zero_level_mode, i_ext_one_level_mode} = 2'b01;
        raise = '0;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        test_regs();
        test_noise();
        test_pdown();
        test_standby();
        test_psave();
        stop_test();
    end
endmodule
`default_nettype wire
